// ===== hw/sbom_regs.svh
`ifndef SBOM_REGS_SVH
`define SBOM_REGS_SVH
// Functional notes
// - Six modes, exactly one active.
// - Init entered at power-up and at soft reset from normal, stop or sleep.
// - Stop keeps main regulator on.
// - Sleep switches main regulator off.
// - Wake in sleep or fail-safe, or failure, enters restart; reset asserted.
// - Restart leaves to normal after reset delay.
// - Critical failure enters fail-safe, regulator off.
// - Fail-safe until wake or overtemperature clears.
// - Development mode halts watchdog, modes allowed.
// - Development selected by test pin low in init.
// - Host configures over 16-bit SPI.
// - Host writes mode field; device switches only normal to stop or sleep, and stop to normal.
// - Mode field cleared passing through restart.
// - Start in init with long open window.
// - Latch failure behaviour from interrupt-pin strap.
// - Latch development mode from test pin.
// - Any SPI command in init goes normal.
// - No trigger in long window: failure, restart or fail-safe per strap.
// - Wake events in init are discarded.
`define SBOM_SPI_W          16
`define SBOM_MODE_LSB       0
`define SBOM_MODE_MSB       2
`define SBOM_SYNC_STAGES    2
`define SBOM_CLK_NS         5
`define SBOM_RD_NS          10000
`define SBOM_LW_NS          200000000
`define SBOM_RD_CYC         ((`SBOM_RD_NS + `SBOM_CLK_NS - 1) / `SBOM_CLK_NS)
`define SBOM_LW_CYC         (`SBOM_LW_NS / `SBOM_CLK_NS)
`endif

// ===== hw/sbom_pkg.sv
package sbom_pkg;
    typedef enum logic [2:0] {
        SBOM_INIT     = 3'b000,
        SBOM_NORMAL   = 3'b001,
        SBOM_SLEEP    = 3'b010,
        SBOM_STOP     = 3'b011,
        SBOM_RESTART  = 3'b100,
        SBOM_FAILSAFE = 3'b101
    } sbom_mode_t;
    typedef struct packed {
        logic wd_fail_to_failsafe;
        logic dev_mode;
    } sbom_cfg_t;
    typedef struct packed {
        logic main_regulator_output;
        logic mcu_reset_n;
        logic wd_running;
    } sbom_pwr_t;
endpackage

// ===== hw/sbom_fsm.sv
`timescale 1ns/1ps
`include "sbom_regs.svh"
module sbom_fsm
    import sbom_pkg::*;
#(
    parameter int RD_CYC = `SBOM_RD_CYC,
    parameter int LW_CYC = `SBOM_LW_CYC
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    soft_reset,
    input  wire logic                    spi_cmd_valid,
    input  wire logic [`SBOM_SPI_W-1:0]  spi_cmd_data,
    input  wire logic                    wd_trigger,
    input  wire logic                    int_strap_pin,
    input  wire logic                    fail_out_test_pin,
    input  wire logic                    can_wake,
    input  wire logic                    wake_inputs,
    input  wire logic                    wd_fail,
    input  wire logic                    main_uv,
    input  wire logic                    overtemp,
    output sbom_mode_t                   mode,
    output logic [2:0]                   mode_field,
    output sbom_cfg_t                    cfg,
    output sbom_pwr_t                    pwr,
    output logic                         wd_fail_flag
);
    sbom_mode_t  mode_q, mode_d;
    logic [2:0]  field_q, field_d;
    logic [31:0] cnt_q, cnt_d;
    logic [1:0]  strap_s1_q, strap_s2_q;
    logic        cfg_done_q, fail_q, flag_q;
    logic        failsafe_cfg_q, dev_q;
    logic [1:0]  cfg_wait_q;

    // Synchronise the two strap pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end else begin
            strap_s1_q <= {int_strap_pin, fail_out_test_pin};
            strap_s2_q <= strap_s1_q;
        end
    end

    wire  [2:0] req_mode   = spi_cmd_data[`SBOM_MODE_MSB:`SBOM_MODE_LSB];
    wire        wake_any   = can_wake | wake_inputs;
    wire        failure    = wd_fail | main_uv | fail_q;
    wire        wd_halted  = dev_q;
    wire        lw_expired = (mode_q == SBOM_INIT) && !wd_halted
                             && (cnt_q >= 32'(LW_CYC - 1));
    wire        lp_req     = (req_mode == 3'(SBOM_STOP)) || (req_mode == 3'(SBOM_SLEEP));
    // Stop is left by a host request for normal; sleep by no request, only by a wake, a failure or soft reset
    wire        wake_req   = (req_mode == 3'(SBOM_NORMAL)) && (mode_q == SBOM_STOP);
    wire        req_ok     = spi_cmd_valid
                             && (((mode_q == SBOM_NORMAL) && lp_req) || wake_req);
    wire        reg_on     = !(mode_q == SBOM_SLEEP || mode_q == SBOM_FAILSAFE);
    wire        mcu_run_n  = (mode_q != SBOM_RESTART);
    wire        wd_run     = !wd_halted && (mode_q != SBOM_SLEEP) && (mode_q != SBOM_FAILSAFE);

    always_comb begin
        mode_d  = mode_q;
        field_d = field_q;
        cnt_d   = cnt_q + 32'h1;
        case (mode_q)
            SBOM_INIT: begin
                // Wake inputs ignored here
                if (soft_reset) begin
                    cnt_d = 32'h0;
                end else if (spi_cmd_valid) begin
                    mode_d  = SBOM_NORMAL;
                    field_d = 3'(SBOM_NORMAL);
                end else if (lw_expired || failure) begin
                    mode_d  = failsafe_cfg_q ? SBOM_FAILSAFE : SBOM_RESTART;
                    cnt_d   = 32'h0;
                end
            end
            SBOM_NORMAL, SBOM_STOP, SBOM_SLEEP: begin
                if (soft_reset) begin
                    mode_d = SBOM_INIT;
                    cnt_d  = 32'h0;
                end else if (failure) begin
                    mode_d = (failsafe_cfg_q && wd_fail) ? SBOM_FAILSAFE : SBOM_RESTART;
                    cnt_d  = 32'h0;
                end else if (mode_q == SBOM_SLEEP && wake_any) begin
                    mode_d = SBOM_RESTART;
                    cnt_d  = 32'h0;
                end else if (req_ok) begin
                    mode_d  = sbom_mode_t'(req_mode);
                    field_d = req_mode;
                end
            end
            SBOM_RESTART: begin
                field_d = 3'h0;
                if (failure) begin
                    cnt_d = 32'h0;
                end else if (cnt_q >= 32'(RD_CYC - 1)) begin
                    mode_d  = SBOM_NORMAL;
                    field_d = 3'(SBOM_NORMAL);
                end
            end
            SBOM_FAILSAFE: begin
                if (wake_any || !overtemp) begin
                    mode_d = SBOM_RESTART;
                    cnt_d  = 32'h0;
                end
            end
            default: begin
                mode_d = SBOM_INIT;
                cnt_d  = 32'h0;
            end
        endcase
        // Field reads zero from the first restart cycle on
        if (mode_d == SBOM_RESTART) begin
            field_d = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q  <= SBOM_INIT;
            field_q <= 3'h0;
            cnt_q   <= 32'h0;
            fail_q  <= 1'b0;
            flag_q  <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            field_q <= field_d;
            cnt_q   <= cnt_d;
            fail_q  <= 1'b0;
            if (lw_expired && !wd_trigger) flag_q <= 1'b1;
            else if (spi_cmd_valid) flag_q <= 1'b0;
        end
    end

    // Strap latch once after power-on, when the synchroniser holds the pin level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_done_q     <= 1'b0;
            cfg_wait_q     <= 2'h0;
            failsafe_cfg_q <= 1'b1;
            dev_q          <= 1'b0;
        end else if (!cfg_done_q && mode_q == SBOM_INIT) begin
            if (cfg_wait_q != 2'(`SBOM_SYNC_STAGES)) begin
                cfg_wait_q <= cfg_wait_q + 2'h1;
            end else begin
                cfg_done_q     <= 1'b1;
                failsafe_cfg_q <= !strap_s2_q[1];
                dev_q          <= !strap_s2_q[0];
            end
        end
    end

    assign mode          = mode_q;
    assign mode_field    = field_q;
    assign cfg           = '{wd_fail_to_failsafe: failsafe_cfg_q, dev_mode: dev_q};
    assign pwr           = '{main_regulator_output: reg_on, mcu_reset_n: mcu_run_n,
                             wd_running: wd_run};
    assign wd_fail_flag  = flag_q;

    sequence s_restart_entry;
        mode_q != SBOM_RESTART ##1 mode_q == SBOM_RESTART;
    endsequence
    sequence s_restart_done;
        mode_q == SBOM_RESTART && !failure && cnt_q >= 32'(RD_CYC - 1);
    endsequence
    sequence s_normal_cmd;
        mode_q == SBOM_NORMAL && spi_cmd_valid && !soft_reset && !failure;
    endsequence
    property p_entry_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        s_restart_entry |-> field_q == 3'h0;
    endproperty
    a_entry_clr: assert property (p_entry_clr) else $error("field kept on restart entry");
    property p_rd_exit;
        @(posedge clk_sys) disable iff (!rst_n)
        s_restart_done |=> mode_q == SBOM_NORMAL && field_q == 3'(SBOM_NORMAL);
    endproperty
    a_rd_exit: assert property (p_rd_exit) else $error("restart not left after delay");
    property p_rd_early;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_RESTART && !failure && cnt_q < 32'(RD_CYC - 1) |=> mode_q == SBOM_RESTART;
    endproperty
    a_rd_early: assert property (p_rd_early) else $error("restart left early");
    property p_restart_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_RESTART && failure |=> mode_q == SBOM_RESTART;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart left in failure");
    property p_mode_legal;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q inside {SBOM_INIT, SBOM_NORMAL, SBOM_SLEEP, SBOM_STOP, SBOM_RESTART,
                       SBOM_FAILSAFE};
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("undefined mode");
    property p_soft_rst;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q inside {SBOM_NORMAL, SBOM_STOP, SBOM_SLEEP} && soft_reset |=> mode_q == SBOM_INIT;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset ignored");
    property p_sleep_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_SLEEP && wake_any && !soft_reset && !failure |=> mode_q == SBOM_RESTART;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake ignored");
    property p_fs_exit;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_FAILSAFE && (wake_any || !overtemp) |=> mode_q == SBOM_RESTART;
    endproperty
    a_fs_exit: assert property (p_fs_exit) else $error("fail-safe not left");
    property p_lw_fail;
        @(posedge clk_sys) disable iff (!rst_n)
        lw_expired && !spi_cmd_valid && !soft_reset
        |=> mode_q == SBOM_FAILSAFE || mode_q == SBOM_RESTART;
    endproperty
    a_lw_fail: assert property (p_lw_fail) else $error("window expiry ignored");
    property p_lw_flag;
        @(posedge clk_sys) disable iff (!rst_n)
        lw_expired && !wd_trigger |=> wd_fail_flag;
    endproperty
    a_lw_flag: assert property (p_lw_flag) else $error("watchdog failure not flagged");
    property p_stop_req;
        @(posedge clk_sys) disable iff (!rst_n)
        s_normal_cmd and (req_mode == 3'(SBOM_STOP))
        |=> mode_q == SBOM_STOP && field_q == 3'(SBOM_STOP);
    endproperty
    a_stop_req: assert property (p_stop_req) else $error("stop request ignored");
    property p_undef;
        @(posedge clk_sys) disable iff (!rst_n)
        s_normal_cmd and !lp_req |=> mode_q == SBOM_NORMAL;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined request taken");
    property p_cfg_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_done_q |=> $stable(failsafe_cfg_q) && $stable(dev_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("strap config changed");
    property p_reg_on;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q inside {SBOM_INIT, SBOM_NORMAL, SBOM_RESTART} |-> pwr.main_regulator_output;
    endproperty
    a_reg_on: assert property (p_reg_on) else $error("regulator off in active mode");
    property p_wd_init;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_INIT && !dev_q |-> pwr.wd_running;
    endproperty
    a_wd_init: assert property (p_wd_init) else $error("watchdog idle in init");
    property p_dev_init;
        @(posedge clk_sys) disable iff (!rst_n)
        dev_q && mode_q == SBOM_INIT && !spi_cmd_valid && !soft_reset && !failure
        |=> mode_q == SBOM_INIT;
    endproperty
    a_dev_init: assert property (p_dev_init) else $error("dev mode init left");

    property p_sleep_off;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_SLEEP |-> !pwr.main_regulator_output;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("regulator on in sleep");
    property p_stop_on;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_STOP |-> pwr.main_regulator_output;
    endproperty
    a_stop_on: assert property (p_stop_on) else $error("regulator off in stop");
    property p_restart_rst;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_RESTART |-> !pwr.mcu_reset_n;
    endproperty
    a_restart_rst: assert property (p_restart_rst) else $error("no reset in restart");
    property p_init_spi;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_INIT && spi_cmd_valid && !soft_reset |=> mode_q == SBOM_NORMAL;
    endproperty
    a_init_spi: assert property (p_init_spi) else $error("init not left on spi");
    property p_field_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_RESTART |=> field_q == 3'h0 || mode_q == SBOM_NORMAL;
    endproperty
    a_field_clr: assert property (p_field_clr) else $error("mode field kept in restart");
    property p_fs_off;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_FAILSAFE |-> !pwr.main_regulator_output;
    endproperty
    a_fs_off: assert property (p_fs_off) else $error("regulator on in fail-safe");
    property p_fs_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_FAILSAFE && !wake_any && overtemp |=> mode_q == SBOM_FAILSAFE;
    endproperty
    a_fs_hold: assert property (p_fs_hold) else $error("fail-safe left early");
    property p_init_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_q == SBOM_INIT && !spi_cmd_valid && !lw_expired && !failure && !soft_reset
        |=> mode_q == SBOM_INIT;
    endproperty
    a_init_wake: assert property (p_init_wake) else $error("init left on wake");
    property p_lp_from_normal;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(mode_q) && (mode_q == SBOM_STOP || mode_q == SBOM_SLEEP)
        |-> $past(mode_q) == SBOM_NORMAL;
    endproperty
    a_lp_from_normal: assert property (p_lp_from_normal) else $error("bad low-power entry");
    property p_dev_wd;
        @(posedge clk_sys) disable iff (!rst_n)
        dev_q |-> !pwr.wd_running;
    endproperty
    a_dev_wd: assert property (p_dev_wd) else $error("watchdog runs in dev mode");
endmodule

// ===== sim/sbom_host.sv
`timescale 1ns/1ps
module sbom_host (
    input  wire logic        clk_sys,
    input  wire logic        mcu_reset_n,
    output logic             spi_cmd_valid,
    output logic [15:0]      spi_cmd_data
);
    initial begin
        spi_cmd_valid = 1'b0;
        spi_cmd_data  = 16'h0000;
    end
    // Host stays silent while it is held in reset; data is scrambled when idle
    task automatic send(input logic [15:0] word);
        @(negedge clk_sys);
        while (mcu_reset_n !== 1'b1) @(negedge clk_sys);
        spi_cmd_valid = 1'b1;
        spi_cmd_data  = word;
        @(negedge clk_sys);
        spi_cmd_valid = 1'b0;
        spi_cmd_data  = ~word;
    endtask
endmodule

// ===== sim/sbom_fsm_test.sv
`timescale 1ns/1ps
module sbom_fsm_test;
    import sbom_pkg::*;
    localparam int RD = 8;
    localparam int LW = 20;
    logic        clk_sys, rst_n, soft_reset, int_strap_pin, fail_out_test_pin;
    logic        can_wake, wake_inputs, wd_fail, main_uv, overtemp;
    logic        spi_cmd_valid, wd_fail_flag, wd_trigger;
    logic [15:0] spi_cmd_data;
    logic [2:0]  mode_field;
    sbom_mode_t  mode;
    sbom_cfg_t   cfg;
    sbom_pwr_t   pwr;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;
    sbom_fsm #(.RD_CYC(RD), .LW_CYC(LW)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .soft_reset(soft_reset),
        .spi_cmd_valid(spi_cmd_valid), .spi_cmd_data(spi_cmd_data), .wd_trigger(wd_trigger),
        .int_strap_pin(int_strap_pin), .fail_out_test_pin(fail_out_test_pin),
        .can_wake(can_wake), .wake_inputs(wake_inputs), .wd_fail(wd_fail),
        .main_uv(main_uv), .overtemp(overtemp), .mode(mode), .mode_field(mode_field),
        .cfg(cfg), .pwr(pwr), .wd_fail_flag(wd_fail_flag));
    sbom_host i_host (.clk_sys(clk_sys), .mcu_reset_n(pwr.mcu_reset_n),
        .spi_cmd_valid(spi_cmd_valid), .spi_cmd_data(spi_cmd_data));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_mode(input sbom_mode_t exp, input int max);
        n = 0;
        while (mode !== exp && n < max) begin
            @(negedge clk_sys);
            n++;
        end
        chk("mode", {13'h0000, mode}, {13'h0000, exp});
    endtask
    task automatic do_reset(input logic test_pin);
        rst_n = 1'b0;
        fail_out_test_pin = test_pin;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("mode", {13'h0000, mode}, 16'h0000);
        chk("field", {13'h0000, mode_field}, 16'h0000);
        chk("cfg", {14'h0000, cfg}, {14'h0000, 1'b1, ~test_pin});
        chk("wd_run", {15'h0000, pwr.wd_running}, {15'h0000, test_pin});
    endtask
    task automatic restart_exit();
        wait_mode(SBOM_RESTART, 6);
        chk("rst_n", {15'h0000, pwr.mcu_reset_n}, 16'h0000);
        chk("field", {13'h0000, mode_field}, 16'h0000);
        wait_mode(SBOM_NORMAL, RD + 6);
        chk("rd_time", {15'h0000, n >= RD - 2 && n <= RD + 1}, 16'h0001);
        chk("field", {13'h0000, mode_field}, 16'h0001);
    endtask
    task automatic t_init_and_modes();
        logic [2:0] req [5] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h2};
        logic [2:0] exp [5] = '{3'h1, 3'h3, 3'h3, 3'h1, 3'h2};
        can_wake = 1'b1;
        wake_inputs = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("init_wake", {13'h0000, mode}, 16'h0000);
        can_wake = 1'b0;
        wake_inputs = 1'b0;
        i_host.send(16'hFFFF);
        wait_mode(SBOM_NORMAL, 2);
        for (int i = 0; i < 5; i++) begin
            i_host.send({13'h0000, req[i]});
            repeat (2) @(negedge clk_sys);
            chk("mode", {13'h0000, mode}, {13'h0000, exp[i]});
            chk("field", {13'h0000, mode_field}, {13'h0000, exp[i]});
            chk("reg", {15'h0000, pwr.main_regulator_output}, {15'h0000, exp[i] != 3'h2});
        end
        wake_inputs = 1'b1;
        @(negedge clk_sys);
        wake_inputs = 1'b0;
        restart_exit();
    endtask
    task automatic t_failures();
        overtemp = 1'b1;
        wd_fail = 1'b1;
        repeat (2) @(negedge clk_sys);
        wd_fail = 1'b0;
        wait_mode(SBOM_FAILSAFE, 4);
        repeat (10) @(negedge clk_sys);
        chk("fs_hold", {13'h0000, mode}, 16'h0005);
        chk("reg", {15'h0000, pwr.main_regulator_output}, 16'h0000);
        overtemp = 1'b0;
        restart_exit();
        main_uv = 1'b1;
        repeat (3) @(negedge clk_sys);
        main_uv = 1'b0;
        restart_exit();
    endtask
    task automatic t_window();
        overtemp = 1'b1;
        soft_reset = 1'b1;
        @(negedge clk_sys);
        soft_reset = 1'b0;
        wait_mode(SBOM_INIT, 3);
        wait_mode(SBOM_FAILSAFE, LW + 6);
        chk("lw_time", {15'h0000, n >= LW - 3}, 16'h0001);
        chk("wd_flag", {15'h0000, wd_fail_flag}, 16'h0001);
        overtemp = 1'b0;
    endtask
    task automatic t_dev();
        do_reset(1'b0);
        repeat (LW + 10) @(negedge clk_sys);
        chk("dev_init", {13'h0000, mode}, 16'h0000);
        i_host.send(16'h0001);
        i_host.send(16'h0003);
        wait_mode(SBOM_STOP, 3);
    endtask
    initial begin
        {wd_trigger, soft_reset, can_wake, wake_inputs, wd_fail, main_uv, overtemp} = 7'h00;
        int_strap_pin = 1'b0;
        do_reset(1'b1);
        t_init_and_modes();
        t_failures();
        t_window();
        t_dev();
        print_verdict();
    end
endmodule
